// [bss_pkg.sv]
// Shared constants for the burst-of-four synchronous SRAM port model.
`default_nettype none

package bss_pkg;

  // ==========================================================================
  // Array and data path widths.
  // ==========================================================================
  localparam int ADDR_W = 6;
  localparam int DATA_W = 18;
  localparam int MASK_W = 2;
  localparam int BURST_LEN = 4;
  localparam int FIFO_DEPTH = 8;
  localparam int FIFO_W = ADDR_W + DATA_W + MASK_W;

  // ==========================================================================
  // Field positions inside one buffered write word.
  // ==========================================================================
  localparam int FLD_MASK_LSB = 0;
  localparam int FLD_DATA_LSB = MASK_W;
  localparam int FLD_ADDR_LSB = MASK_W + DATA_W;

  // ==========================================================================
  // Data width strap codes.
  // ==========================================================================
  localparam logic [1:0] WIDTH_X18 = 2'h0;
  localparam logic [1:0] WIDTH_X9 = 2'h1;
  localparam logic [1:0] WIDTH_X8 = 2'h2;

  // ==========================================================================
  // Read timing, counted in clock-edge events after the starting rise.
  // ==========================================================================
  localparam logic [3:0] RD_FIRST_EV = 4'h5;
  localparam logic [3:0] RD_LAST_EV = 4'h8;

  // ==========================================================================
  // Reset values.
  // ==========================================================================
  localparam logic [DATA_W-1:0] RST_RD_DATA = 18'h0_0000;
  localparam logic [ADDR_W-1:0] RST_ADDR = 6'h00;

endpackage

`default_nettype wire

// [bss_fifo.sv]
// Parameterised valid/ready FIFO used to buffer captured write words.
`default_nettype none

module bss_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk, // System clock.
  input wire logic reset, // Synchronous reset, active high.
  input wire logic [WIDTH-1:0] inData, // Word offered by the source.
  input wire logic inValid, // Source offers a word.
  output logic inReady, // FIFO can take a word.
  output logic [WIDTH-1:0] outData, // Oldest stored word.
  output logic outValid, // A word is available.
  input wire logic outReady // Sink takes the word.
);

  localparam int PTR_W = $clog2(DEPTH);

  logic [WIDTH-1:0] store [DEPTH];
  logic [PTR_W-1:0] rdPtr;
  logic [PTR_W-1:0] wrPtr;
  logic [PTR_W:0] count;
  logic [PTR_W-1:0] next_rdPtr;
  logic [PTR_W-1:0] next_wrPtr;
  logic [PTR_W:0] next_count;
  logic doPush;
  logic doPop;

  // ==========================================================================
  // Flags and handshakes.
  // ==========================================================================
  // Full and empty come straight from the occupancy count.
  assign inReady = (count != (PTR_W + 1)'(DEPTH));
  assign outValid = (count != '0);
  assign outData = store[rdPtr];
  assign doPush = inValid & inReady;
  assign doPop = outValid & outReady;

  // Pointer wrap is explicit because DEPTH need not be a power of two.
  always_comb begin
    next_rdPtr = rdPtr;
    next_wrPtr = wrPtr;
    next_count = count;
    if (doPush) begin
      next_wrPtr = (wrPtr == PTR_W'(DEPTH - 1)) ? '0 : wrPtr + 1'b1;
    end
    if (doPop) begin
      next_rdPtr = (rdPtr == PTR_W'(DEPTH - 1)) ? '0 : rdPtr + 1'b1;
    end
    if (doPush && !doPop) begin
      next_count = count + 1'b1;
    end else if (doPop && !doPush) begin
      next_count = count - 1'b1;
    end
  end

  // Storage has no reset; only the pointers and the count need a defined value.
  always_ff @(posedge clk) begin
    if (reset) begin
      rdPtr <= '0;
      wrPtr <= '0;
      count <= '0;
    end else begin
      rdPtr <= next_rdPtr;
      wrPtr <= next_wrPtr;
      count <= next_count;
    end
    if (doPush) begin
      store[wrPtr] <= inData;
    end
  end

endmodule

`default_nettype wire

// [bss_sram_port.sv]
// Burst-of-four synchronous SRAM port: command decode, bursts and masked array writes.
`default_nettype none

// Contract
// - Write starts on low write select at positive rise; four words follow over t+1, t+2.
// - Read starts on low read select; words at negative t+2, then every edge to t+4.
// - Burst words map to start address, then plus one, two and three.
// - Same-type requests on consecutive positive rises: the second one is discarded.
// - Read select is don't-care on the rise after a read started.
// - After power-up both ports deselected and read outputs high-impedance.
// - x18: mask bit 0 low writes bits 8..0, bit 1 low writes 17..9.
// - x8: nibble mask bit 0 low writes bits 3..0, bit 1 writes 7..4.
// - x9: single mask bit low writes all nine bits; high writes nothing.
// - All mask bits high leaves that word unchanged; burst still completes.
// - Masks sampled with each data word at both clock rises; may change per word.

module bss_sram_port (
  input wire logic clk, // System clock, 20 MHz.
  input wire logic reset, // Synchronous reset, active high.
  input wire logic kClk, // Positive input clock pin.
  input wire logic kClkN, // Negative input clock pin.
  input wire logic readPortSelectN, // Read port select, active low.
  input wire logic writePortSelectN, // Write port select, active low.
  input wire logic [bss_pkg::ADDR_W-1:0] addr, // Shared address pins.
  input wire logic [bss_pkg::DATA_W-1:0] wrData, // Write data pins.
  input wire logic [bss_pkg::MASK_W-1:0] byteWriteMaskN, // Byte or nibble masks, low writes.
  input wire logic [1:0] widthMode, // Static width strap.
  output logic [bss_pkg::DATA_W-1:0] rdData, // Read data pins.
  output logic rdDataOe, // High while read data is driven.
  output logic wrLost // Sticky: a write word found the buffer full.
);

  localparam int NPIN = 4 + bss_pkg::ADDR_W + bss_pkg::DATA_W + bss_pkg::MASK_W + 2;

  // ==========================================================================
  // Pin synchronisers.
  // ==========================================================================
  logic [NPIN-1:0] pinRaw;
  logic [NPIN-1:0] pinS1;
  logic [NPIN-1:0] pinS2;
  logic kPrev;
  logic kNPrev;

  assign pinRaw = {kClk, kClkN, readPortSelectN, writePortSelectN, addr, wrData,
                   byteWriteMaskN, widthMode};

  // Every pin shares one depth so data stays aligned with the detected clock rise.
  always_ff @(posedge clk) begin
    pinS1 <= pinRaw;
    pinS2 <= pinS1;
    kPrev <= pinS2[NPIN-1];
    kNPrev <= pinS2[NPIN-2];
  end

  logic sK;
  logic sKN;
  logic sRpsN;
  logic sWpsN;
  logic [bss_pkg::ADDR_W-1:0] sAddr;
  logic [bss_pkg::DATA_W-1:0] sData;
  logic [bss_pkg::MASK_W-1:0] sMaskN;
  logic [1:0] sWidth;
  logic posEv;
  logic negEv;

  assign {sK, sKN, sRpsN, sWpsN, sAddr, sData, sMaskN, sWidth} = pinS2;
  // With the input clocks stopped no event fires, so all command and burst state below holds; buffered writes still drain.
  assign posEv = sK & ~kPrev;
  assign negEv = sKN & ~kNPrev;

  // ==========================================================================
  // Helpers.
  // ==========================================================================
  function automatic logic [bss_pkg::ADDR_W-1:0] burstAddr(
    input logic [bss_pkg::ADDR_W-1:0] base,
    input logic [3:0] idx
  );
    burstAddr = base + bss_pkg::ADDR_W'(idx);
  endfunction

  // Turn the active-low masks into a per-bit write enable for the strapped width.
  function automatic logic [bss_pkg::DATA_W-1:0] bitEnable(
    input logic [1:0] width,
    input logic [bss_pkg::MASK_W-1:0] maskN
  );
    bitEnable = '0;
    if (width == bss_pkg::WIDTH_X8) begin
      bitEnable[3:0] = {4{~maskN[0]}};
      bitEnable[7:4] = {4{~maskN[1]}};
    end else if (width == bss_pkg::WIDTH_X9) begin
      bitEnable[8:0] = {9{~maskN[0]}};
    end else begin
      bitEnable[8:0] = {9{~maskN[0]}};
      bitEnable[17:9] = {9{~maskN[1]}};
    end
  endfunction

  // ==========================================================================
  // Write word buffer and array.
  // ==========================================================================
  logic [bss_pkg::DATA_W-1:0] mem [2**bss_pkg::ADDR_W];
  logic pushValid;
  logic [bss_pkg::FIFO_W-1:0] pushWord;
  logic pushReady;
  logic [bss_pkg::FIFO_W-1:0] popWord;
  logic popValid;
  logic readFetch;
  logic drain;
  logic [bss_pkg::ADDR_W-1:0] popAddr;
  logic [bss_pkg::DATA_W-1:0] popData;
  logic [bss_pkg::DATA_W-1:0] popEn;

  // Array is modelled single ported: a read fetch stalls the drain for a cycle.
  bss_fifo #(
    .WIDTH(bss_pkg::FIFO_W),
    .DEPTH(bss_pkg::FIFO_DEPTH)
  ) writeBuf (
    .clk(clk),
    .reset(reset),
    .inData(pushWord),
    .inValid(pushValid),
    .inReady(pushReady),
    .outData(popWord),
    .outValid(popValid),
    .outReady(~readFetch)
  );

  assign drain = popValid & ~readFetch;
  assign popAddr = popWord[bss_pkg::FLD_ADDR_LSB +: bss_pkg::ADDR_W];
  assign popData = popWord[bss_pkg::FLD_DATA_LSB +: bss_pkg::DATA_W];
  assign popEn = bitEnable(sWidth, popWord[bss_pkg::FLD_MASK_LSB +: bss_pkg::MASK_W]);

  // Masked bits keep their stored value; a fully masked word changes nothing.
  always_ff @(posedge clk) begin
    if (drain) begin
      mem[popAddr] <= (mem[popAddr] & ~popEn) | (popData & popEn);
    end
  end

  // ==========================================================================
  // Command decode, write capture and read bursts.
  // ==========================================================================
  logic lastRead;
  logic lastWrite;
  logic pendValid;
  logic [bss_pkg::ADDR_W-1:0] pendAddr;
  logic wrAct;
  logic [3:0] wrIdx;
  logic [bss_pkg::ADDR_W-1:0] wrBase;
  logic [1:0] rdBusy;
  logic [3:0] rdCnt [2];
  logic [bss_pkg::ADDR_W-1:0] rdBase [2];
  logic rdSel;
  logic next_lastRead;
  logic next_lastWrite;
  logic next_pendValid;
  logic [bss_pkg::ADDR_W-1:0] next_pendAddr;
  logic next_wrAct;
  logic [3:0] next_wrIdx;
  logic [bss_pkg::ADDR_W-1:0] next_wrBase;
  logic [1:0] next_rdBusy;
  logic [3:0] next_rdCnt [2];
  logic [bss_pkg::ADDR_W-1:0] next_rdBase [2];
  logic next_rdSel;
  logic [bss_pkg::DATA_W-1:0] next_rdData;
  logic next_rdDataOe;
  logic next_wrLost;
  logic startRead;
  logic startWrite;
  logic capture;
  logic wordOut;
  logic [3:0] evCnt;

  // One event step per detected rise; the order inside mirrors the burst timeline.
  always_comb begin
    next_lastRead = lastRead;
    next_lastWrite = lastWrite;
    next_pendValid = pendValid;
    next_pendAddr = pendAddr;
    next_wrAct = wrAct;
    next_wrIdx = wrIdx;
    next_wrBase = wrBase;
    next_rdBusy = rdBusy;
    next_rdCnt = rdCnt;
    next_rdBase = rdBase;
    next_rdSel = rdSel;
    next_rdData = rdData;
    next_rdDataOe = rdDataOe;
    next_wrLost = wrLost;
    startRead = 1'b0;
    startWrite = 1'b0;
    capture = 1'b0;
    wordOut = 1'b0;
    readFetch = 1'b0;
    evCnt = 4'h0;

    // Even words are taken at positive rises, odd words at negative rises.
    if (posEv) begin
      if (wrAct && wrIdx == 4'h2) begin
        capture = 1'b1;
      end else if (pendValid) begin
        capture = 1'b1;
        next_wrAct = 1'b1;
        next_wrBase = pendAddr;
        next_wrIdx = 4'h0;
        next_pendValid = 1'b0;
      end
    end else if (negEv && wrAct && wrIdx[0]) begin
      capture = 1'b1;
    end
    pushValid = capture;
    pushWord = {burstAddr(next_wrBase, next_wrIdx), sData, sMaskN};
    if (capture) begin
      next_wrIdx = next_wrIdx + 4'h1;
      if (next_wrIdx == 4'(bss_pkg::BURST_LEN)) begin
        next_wrAct = 1'b0;
      end
      if (!pushReady) begin
        next_wrLost = 1'b1;
      end
    end

    // Advance every read in flight and drive its word at events five to eight.
    if (posEv || negEv) begin
      for (int i = 0; i < 2; i++) begin
        if (rdBusy[i]) begin
          evCnt = rdCnt[i] + 4'h1;
          next_rdCnt[i] = evCnt;
          if (evCnt >= bss_pkg::RD_FIRST_EV) begin
            wordOut = 1'b1;
            readFetch = 1'b1;
            next_rdData = mem[burstAddr(rdBase[i], evCnt - bss_pkg::RD_FIRST_EV)];
            next_rdDataOe = 1'b1;
          end
          if (evCnt == bss_pkg::RD_LAST_EV) begin
            next_rdBusy[i] = 1'b0;
          end
        end
      end
      // Release the pins on the first negative rise with no word to drive.
      if (negEv && !wordOut) begin
        next_rdDataOe = 1'b0;
      end
    end

    // Decode selects; a select right after its own start is ignored.
    if (posEv) begin
      startRead = ~sRpsN & ~lastRead;
      startWrite = ~sWpsN & ~lastWrite;
      // After a read the read select is don't-care, so a write may start.
      if (lastRead) begin
        startRead = 1'b0;
      end
      // Both selected from idle: the read starts, the write is dropped.
      if (startRead && startWrite) begin
        startWrite = 1'b0;
      end
      // Both selects high start nothing; data pins are taken only by a write burst in flight.
      next_lastRead = startRead;
      next_lastWrite = startWrite;
      if (startWrite) begin
        next_pendValid = 1'b1;
        next_pendAddr = sAddr;
      end
      if (startRead) begin
        next_rdBusy[rdSel] = 1'b1;
        next_rdCnt[rdSel] = 4'h0;
        next_rdBase[rdSel] = sAddr;
        next_rdSel = ~rdSel;
      end
    end
  end

  // Reset leaves both ports deselected and the read pins released.
  always_ff @(posedge clk) begin
    if (reset) begin
      lastRead <= 1'b0;
      lastWrite <= 1'b0;
      pendValid <= 1'b0;
      pendAddr <= bss_pkg::RST_ADDR;
      wrAct <= 1'b0;
      wrIdx <= 4'h0;
      wrBase <= bss_pkg::RST_ADDR;
      rdBusy <= 2'h0;
      rdCnt <= '{default: 4'h0};
      rdBase <= '{default: bss_pkg::RST_ADDR};
      rdSel <= 1'b0;
      rdData <= bss_pkg::RST_RD_DATA;
      rdDataOe <= 1'b0;
      wrLost <= 1'b0;
    end else begin
      lastRead <= next_lastRead;
      lastWrite <= next_lastWrite;
      pendValid <= next_pendValid;
      pendAddr <= next_pendAddr;
      wrAct <= next_wrAct;
      wrIdx <= next_wrIdx;
      wrBase <= next_wrBase;
      rdBusy <= next_rdBusy;
      rdCnt <= next_rdCnt;
      rdBase <= next_rdBase;
      rdSel <= next_rdSel;
      rdData <= next_rdData;
      rdDataOe <= next_rdDataOe;
      wrLost <= next_wrLost;
    end
  end

endmodule

`default_nettype wire

// [bss_sram_port_checker.sv]
// Property checker for the SRAM port read timing and output hold.
`default_nettype none
module bss_sram_port_checker (
  input wire logic clk, // System clock.
  input wire logic reset, // Synchronous reset.
  input wire logic kClk, // Positive input clock.
  input wire logic kClkN, // Negative input clock.
  input wire logic readPortSelectN, // Read select, active low.
  input wire logic [bss_pkg::DATA_W-1:0] rdData, // Read data.
  input wire logic rdDataOe, // Read data driven.
  input wire logic wrLost // Write overflow flag.
);
  timeunit 1ns;
  timeprecision 1ps;
  // =====
  // Edges
  // =====
  logic [2:0] kP, kN, rS;
  logic [8:0] hist, next_hist;
  logic lastRd, next_lastRd, posRise, negRise, ev, rdGo, due;
  // Edges and read starts as the two-stage synchronisers of the port see them.
  always_comb begin
    posRise = kP[1] & ~kP[2];
    negRise = kN[1] & ~kN[2];
    ev = posRise | negRise;
    rdGo = posRise & ~rS[1] & ~lastRd;
    next_hist = reset ? 9'h000 : (ev ? {hist[7:0], rdGo} : hist);
    next_lastRd = reset ? 1'b0 : (posRise ? rdGo : lastRd);
    due = |next_hist[8:5];
  end
  // Pin samplers stay out of reset so that a pin held high is not taken for a rise.
  always_ff @(posedge clk) begin
    kP <= {kP[1:0], kClk};
    kN <= {kN[1:0], kClkN};
    rS <= {rS[1:0], readPortSelectN};
    hist <= next_hist;
    lastRd <= next_lastRd;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  a_reset_quiet: assert property (disable iff (1'b0) reset |=> !rdDataOe && !wrLost)
    else $error("outputs not quiet after reset");
  a_reset_data: assert property (disable iff (1'b0) reset |=> rdData == bss_pkg::RST_RD_DATA)
    else $error("read data not cleared by reset");
  a_word_driven: assert property (ev && due |=> rdDataOe)
    else $error("read word not driven when due");
  a_idle_float: assert property (ev && negRise && !due |=> !rdDataOe)
    else $error("read data driven with no word due");
  a_read_latency: assert property (rdGo && !rdDataOe && hist == 9'h000 |=> !rdDataOe [*8])
    else $error("read data came too early");
  a_data_holds: assert property (!$past(ev) |-> $stable(rdData))
    else $error("read data moved without a clock edge");
  a_oe_holds: assert property (!$past(ev) |-> $stable(rdDataOe))
    else $error("output enable moved without a clock edge");
  a_oe_rise_neg: assert property ($rose(rdDataOe) |-> $past(negRise))
    else $error("output enable rose off a negative rise");
  a_data_live: assert property ($changed(rdData) |-> rdDataOe)
    else $error("read data changed while floating");
  a_lost_sticky: assert property (wrLost |=> wrLost)
    else $error("lost-write flag cleared");
  c_word: cover property (ev && due);
  c_dropped: cover property (posRise && !rS[1] && lastRd);
  c_float: cover property ($fell(rdDataOe));
endmodule
bind bss_sram_port bss_sram_port_checker chk (.clk(clk), .reset(reset), .kClk(kClk),
  .kClkN(kClkN), .readPortSelectN(readPortSelectN), .rdData(rdData), .rdDataOe(rdDataOe),
  .wrLost(wrLost));
`default_nettype wire

// [bss_ctl_model.sv]
// Controller model that drives the port pins one input-clock half at a time.
`default_nettype none
module bss_ctl_model (
  input wire logic clk, // System clock; pins move on its falling edge.
  output logic kClk, // Positive input clock.
  output logic kClkN, // Negative input clock.
  output logic readPortSelectN, // Read select, active low.
  output logic writePortSelectN, // Write select, active low.
  output logic [bss_pkg::ADDR_W-1:0] addr, // Address.
  output logic [bss_pkg::DATA_W-1:0] wrData, // Write data.
  output logic [bss_pkg::MASK_W-1:0] byteWriteMaskN, // Write masks, active low.
  input wire logic [bss_pkg::DATA_W-1:0] rdData, // Read data.
  input wire logic rdDataOe // Read data driven.
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle pins; both clocks high is avoided since raising one would itself be an edge.
  initial begin
    kClk = 1'b0;
    kClkN = 1'b1;
    readPortSelectN = 1'b1;
    writePortSelectN = 1'b1;
    addr = 6'h00;
    wrData = 18'h0_0000;
    byteWriteMaskN = 2'h3;
  end
  // Pins settle four clocks, the edge is made, pins hold four more, then data is taken.
  task automatic step(input logic pos, input logic rs, input logic ws,
    input logic [bss_pkg::ADDR_W-1:0] a, input logic [bss_pkg::DATA_W-1:0] d,
    input logic [1:0] m, output logic [bss_pkg::DATA_W-1:0] q, output logic oe);
    @(negedge clk);
    readPortSelectN = rs;
    writePortSelectN = ws;
    addr = a;
    wrData = d;
    byteWriteMaskN = m;
    repeat (4) @(negedge clk);
    kClk = pos;
    kClkN = ~pos;
    repeat (4) @(negedge clk);
    q = rdData;
    oe = rdDataOe;
  endtask
endmodule
`default_nettype wire

// [bss_sram_port_test.sv]
// Self-checking testbench for the burst-of-four SRAM port.
`default_nettype none
module bss_sram_port_test;
  timeunit 1ns;
  timeprecision 1ps;
  typedef logic [bss_pkg::DATA_W-1:0] bss_word_t;
  typedef logic [bss_pkg::ADDR_W-1:0] bss_addr_t;
  localparam int LIMIT = 3000;
  logic clk, reset;
  logic [1:0] widthMode;
  wire logic kClk, kClkN, rdSelN, wrSelN, rdDataOe, wrLost;
  wire bss_addr_t addr;
  wire bss_word_t wrData, rdData;
  wire logic [1:0] maskN;
  int fails = 0, cmpCount = 0, cycles = 0;
  logic sR[32], sW[32], qOe[64], eOe[64];
  bss_addr_t sA[32];
  bss_word_t sD[64], qD[64], eD[64], mem[64];
  logic [1:0] sM[64];
  bss_sram_port uut (.clk(clk), .reset(reset), .kClk(kClk), .kClkN(kClkN),
    .readPortSelectN(rdSelN), .writePortSelectN(wrSelN), .addr(addr), .wrData(wrData),
    .byteWriteMaskN(maskN), .widthMode(widthMode), .rdData(rdData), .rdDataOe(rdDataOe),
    .wrLost(wrLost));
  bss_ctl_model ctl (.clk(clk), .kClk(kClk), .kClkN(kClkN), .readPortSelectN(rdSelN),
    .writePortSelectN(wrSelN), .addr(addr), .wrData(wrData), .byteWriteMaskN(maskN),
    .rdData(rdData), .rdDataOe(rdDataOe));
  // =======
  // Helpers
  // =======
  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", cmpCount, fails);
    if (fails == 0 && cmpCount > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic check(string what, bss_word_t seen, bss_word_t exp);
    cmpCount++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Bits that carry data in the current width.
  function automatic bss_word_t live();
    if (widthMode == bss_pkg::WIDTH_X9) return 18'h0_01ff;
    if (widthMode == bss_pkg::WIDTH_X8) return 18'h0_00ff;
    return 18'h3_ffff;
  endfunction
  function automatic bss_word_t merge(bss_word_t o, bss_word_t n, logic [1:0] m);
    bss_word_t en;
    en = {{9{~m[1]}}, {9{~m[0]}}};
    if (widthMode == bss_pkg::WIDTH_X9) en = m[0] ? 18'h0_0000 : 18'h0_01ff;
    if (widthMode == bss_pkg::WIDTH_X8) en = {10'h000, {4{~m[1]}}, {4{~m[0]}}};
    return (o & ~en) | (n & en);
  endfunction
  // Idle script: junk data with masks enabled, so stray writes would show later.
  task automatic clear();
    for (int i = 0; i < 64; i++) begin
      sD[i] = 18'h2_5a5a ^ bss_word_t'(i * 37);
      sM[i] = 2'h0;
      eOe[i] = 1'b0;
      sR[i / 2] = 1'b1;
      sW[i / 2] = 1'b1;
      sA[i / 2] = bss_addr_t'(i * 5 + 7);
    end
  endtask
  task automatic wr(int c, bss_addr_t a, bss_word_t d, logic [7:0] m);
    int h;
    sW[c] = 1'b0;
    sA[c] = a;
    for (int k = 0; k < 4; k++) begin
      h = 2 * c + 2 + k;
      sD[h] = d + bss_word_t'(k * 4097);
      sM[h] = m[2 * k +: 2];
      mem[a + bss_addr_t'(k)] = merge(mem[a + bss_addr_t'(k)], sD[h], sM[h]);
    end
  endtask
  task automatic rd(int c, bss_addr_t a);
    sR[c] = 1'b0;
    sA[c] = a;
    for (int k = 0; k < 4; k++) begin
      eOe[2 * c + 5 + k] = 1'b1;
      eD[2 * c + 5 + k] = mem[a + bss_addr_t'(k)];
    end
  endtask
  task automatic play(int from, int to);
    for (int c = from; c < to; c++) begin
      ctl.step(1'b1, sR[c], sW[c], sA[c], sD[2 * c], sM[2 * c], qD[2 * c], qOe[2 * c]);
      ctl.step(1'b0, 1'b1, 1'b1, ~sA[c], sD[2 * c + 1], sM[2 * c + 1], qD[2 * c + 1],
        qOe[2 * c + 1]);
    end
  endtask
  task automatic judge(int from, int to);
    for (int i = 2 * from; i < 2 * to; i++) begin
      check("rdDataOe", bss_word_t'(qOe[i]), bss_word_t'(eOe[i]));
      if (eOe[i]) check("rdData", qD[i] & live(), eD[i] & live());
    end
  endtask
  // =========
  // Scenarios
  // =========
  task automatic t_burst();
    clear();
    wr(0, 6'h3e, 18'h1_1110, 8'h00);
    wr(2, 6'h20, 18'h2_2220, 8'h00);
    wr(4, 6'h30, 18'h3_3330, 8'h00);
    play(0, 7);
    clear();
    rd(0, 6'h3e);
    rd(2, 6'h20);
    play(0, 8);
    judge(0, 8);
  endtask
  task automatic t_same();
    clear();
    rd(0, 6'h3e);
    sR[1] = 1'b0;
    wr(1, 6'h10, 18'h0_4440, 8'h00);
    sW[2] = 1'b0;
    sA[2] = 6'h20;
    play(0, 7);
    judge(0, 7);
    clear();
    rd(0, 6'h10);
    rd(2, 6'h20);
    // Both selects low from idle: the read wins and the junk write must not land.
    sW[2] = 1'b0;
    play(0, 7);
    judge(0, 7);
  endtask
  task automatic t_masks();
    clear();
    wr(0, 6'h10, 18'h3_c3c5, 8'he4);
    rd(3, 6'h10);
    play(0, 8);
    judge(0, 8);
  endtask
  task automatic t_widths();
    logic [1:0] modes[2];
    modes = '{bss_pkg::WIDTH_X8, bss_pkg::WIDTH_X9};
    for (int i = 0; i < 2; i++) begin
      @(negedge clk);
      widthMode = modes[i];
      clear();
      play(0, 2);
      wr(2, 6'h30, 18'h0_0a5c, 8'he4);
      rd(5, 6'h30);
      play(2, 10);
      judge(2, 10);
    end
    @(negedge clk);
    widthMode = bss_pkg::WIDTH_X18;
    play(0, 2);
  endtask
  // Clocks stop with the first word out; it must stand until they resume.
  task automatic t_stop();
    clear();
    rd(0, 6'h3e);
    play(0, 3);
    repeat (100) @(negedge clk);
    check("rdData", rdData & live(), eD[5] & live());
    check("rdDataOe", bss_word_t'(rdDataOe), 18'h0_0001);
    play(3, 6);
    judge(0, 6);
  endtask
  // Free-running 20 MHz clock.
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Cycle ceiling so that a stuck port cannot hang the run.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      fails++;
      stop_test();
    end
  end
  // Main sequence.
  initial begin
    reset = 1'b1;
    widthMode = bss_pkg::WIDTH_X18;
    repeat (12) @(negedge clk);
    reset = 1'b0;
    check("rdDataOe", bss_word_t'(rdDataOe), 18'h0_0000);
    check("rdData", rdData, bss_pkg::RST_RD_DATA);
    t_burst();
    t_same();
    t_masks();
    t_widths();
    t_stop();
    check("wrLost", bss_word_t'(wrLost), 18'h0_0000);
    stop_test();
  end
endmodule
`default_nettype wire
